/* File: logic/vpm_top.sv */
// How it works
// - The card-present strap on the parity pin is caught after reset, and a 0 there selects video mode.
// - The eight sideband address pins are caught as an 8-bit card identifier readable by software.
// - In blank mode the port C blank output is active only over active pixels without border.
// - In border mode the port C blank output is active over active and border pixels, chosen by software.
// - The shared interrupt input is taken as an active-low request from either video device.
// - The port C field/stall input is set by software to act as TV field or as panel stall.
// - In field mode with an interleaved overlay, the overlay field follows the encoder's field.
// - In stall mode an active stall holds off pixel output for one horizontal line.
// - The field/stall input has programmable polarity and can be ignored entirely.
// - All six display control and DDC lines float while hard reset is held.
// - In video mode the secondary DDC clock and data lines work as an open two-wire channel; in port mode they are never driven.
// - In video mode each video signal goes to its fixed graphics port pin.
// - Each port sends 12 data bits on both edges of its differential clock, 24 bits per period.
module vpm_top
    import vpm_pkg::*;
#(
    parameter int PIX_W = VPM_PIX_W
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic graphics_port_parity_pin,
    input wire logic [7:0] graphics_sideband_addr_pins,
    input wire logic link_clk,
    input wire vpm_video_s port_b_video,
    input wire vpm_video_s port_c_video,
    output vpm_pins_s pins_o,
    output logic video_mode_o,
    input wire logic shared_video_irq_n,
    input wire logic port_c_field_stall_in,
    output logic overlay_field_o,
    output logic stall_hold_o,
    input wire logic hsync_tick,
    input wire logic [5:0] ddc_i,
    output logic [5:0] ddc_o,
    output logic [5:0] ddc_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Synchronisers (three stages, change on 2nd==3rd)
    // ----------------------------------------
    logic [2:0] lk_s_q, irq_s_q, fs_s_q;
    logic lk_q, irq_lvl_q, fs_lvl_q;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            lk_s_q <= 3'h0;
            irq_s_q <= 3'h7;
            fs_s_q <= 3'h0;
            lk_q <= 1'b0;
            irq_lvl_q <= 1'b1;
            fs_lvl_q <= 1'b0;
        end
        else
        begin
            lk_s_q <= {lk_s_q[1:0], link_clk};
            irq_s_q <= {irq_s_q[1:0], shared_video_irq_n};
            fs_s_q <= {fs_s_q[1:0], port_c_field_stall_in};
            if (lk_s_q[1] == lk_s_q[2])
                lk_q <= lk_s_q[2];
            if (irq_s_q[1] == irq_s_q[2])
                irq_lvl_q <= irq_s_q[2];
            if (fs_s_q[1] == fs_s_q[2])
                fs_lvl_q <= fs_s_q[2];
        end
    end

    // ----------------------------------------
    // Straps, caught in the first cycle after release
    // ----------------------------------------
    logic strap_done_q, video_q;
    logic [7:0] card_id_strap_q;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            strap_done_q <= 1'b0;
            video_q <= 1'b0;
            card_id_strap_q <= 8'h00;
        end
        else if (!strap_done_q)
        begin
            strap_done_q <= 1'b1;
            video_q <= ~graphics_port_parity_pin;
            card_id_strap_q <= graphics_sideband_addr_pins;
        end
    end
    assign video_mode_o = video_q;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0] ctrl_q;
    logic [VPM_IRQ_W-1:0] irq_stat_q, irq_en_q, irq_set;
    logic [5:0] ddc_drv_q;
    logic wr, rd;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl_q <= VPM_CTRL_RST;
            irq_en_q <= '0;
            ddc_drv_q <= 6'h00;
        end
        else if (wr && wb_sel_i[0])
        begin
            if (wb_adr_i == VPM_ADDR_CTRL)
                ctrl_q <= {24'h000000, wb_dat_i[7:0]};
            if (wb_adr_i == VPM_ADDR_IRQ_EN)
                irq_en_q <= wb_dat_i[VPM_IRQ_W-1:0];
            if (wb_adr_i == VPM_ADDR_DDC)
                ddc_drv_q <= wb_dat_i[5:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (rd)
            begin
                case (wb_adr_i)
                    VPM_ADDR_CTRL: wb_dat_o <= ctrl_q;
                    VPM_ADDR_STRAP: wb_dat_o <= {23'h000000, video_q, card_id_strap_q};
                    VPM_ADDR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_q};
                    VPM_ADDR_IRQ_EN: wb_dat_o <= {29'h0, irq_en_q};
                    VPM_ADDR_DDC: wb_dat_o <= {26'h0, ddc_drv_q};
                    VPM_ADDR_STATUS: wb_dat_o <= {26'h0, ddc_i};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Field / stall input
    // ----------------------------------------
    logic fs_act, fs_prev_q, stall_pend_q, field_q, stall_q;
    assign fs_act = ctrl_q[VPM_CTRL_FS_EN] && (fs_lvl_q ^ ctrl_q[VPM_CTRL_FS_POL]);
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            fs_prev_q <= 1'b0;
            field_q <= 1'b0;
            stall_pend_q <= 1'b0;
            stall_q <= 1'b0;
        end
        else
        begin
            fs_prev_q <= fs_act;
            if (!ctrl_q[VPM_CTRL_FS_STALL] && ctrl_q[VPM_CTRL_INTERLEAVE])
                field_q <= fs_act;
            // Stall request is latched and served for one whole line
            if (ctrl_q[VPM_CTRL_FS_STALL] && fs_act && !fs_prev_q)
                stall_pend_q <= 1'b1;
            else if (hsync_tick && stall_pend_q)
                stall_pend_q <= 1'b0;
            if (hsync_tick)
                stall_q <= stall_pend_q;
        end
    end
    assign overlay_field_o = field_q;
    assign stall_hold_o = stall_q;

    // ----------------------------------------
    // Interrupts (set wins over clear)
    // ----------------------------------------
    assign irq_set = {ctrl_q[VPM_CTRL_FS_STALL] && fs_act && !fs_prev_q,
                      !ctrl_q[VPM_CTRL_FS_STALL] && fs_act != fs_prev_q,
                      !irq_lvl_q};
    logic [VPM_IRQ_W-1:0] irq_clr;
    assign irq_clr = (wr && wb_sel_i[0] && wb_adr_i == VPM_ADDR_IRQ_CLR) ? wb_dat_i[VPM_IRQ_W-1:0] : '0;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_stat_q <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            irq_o <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
        end
    end

    // ----------------------------------------
    // Pixel output: half word per link clock edge
    // ----------------------------------------
    logic lk_prev_q, lk_edge;
    assign lk_edge = lk_q != lk_prev_q;
    logic [PIX_W-1:0] b_half, c_half;
    logic c_blank_n;
    always_comb
    begin
        b_half = lk_q ? port_b_video.pixel[VPM_WORD_W-1:PIX_W] : port_b_video.pixel[PIX_W-1:0];
        c_half = lk_q ? port_c_video.pixel[VPM_WORD_W-1:PIX_W] : port_c_video.pixel[PIX_W-1:0];
        if (ctrl_q[VPM_CTRL_BORDER])
            c_blank_n = !(port_c_video.active || port_c_video.border);
        else
            c_blank_n = !(port_c_video.active && !port_c_video.border);
    end

    vpm_pins_s pins_d;
    always_comb
    begin
        pins_d = '0;
        pins_d.ad_o[3] = b_half[0];
        pins_d.ad_o[2] = b_half[1];
        pins_d.ad_o[5] = b_half[2];
        pins_d.ad_o[4] = b_half[3];
        pins_d.ad_o[7] = b_half[4];
        pins_d.ad_o[6] = b_half[5];
        pins_d.ad_o[8] = b_half[6];
        pins_d.be_n_o[0] = b_half[7];
        pins_d.ad_o[10] = b_half[8];
        pins_d.ad_o[9] = b_half[9];
        pins_d.ad_o[12] = b_half[10];
        pins_d.ad_o[11] = b_half[11];
        pins_d.ad_o[0] = port_b_video.hsync;
        pins_d.ad_o[1] = port_b_video.vsync;
        pins_d.be_n_o[1] = !(port_b_video.active && !port_b_video.border);
        pins_d.ad_o[19] = c_half[0];
        pins_d.ad_o[20] = c_half[1];
        pins_d.ad_o[21] = c_half[2];
        pins_d.ad_o[22] = c_half[3];
        pins_d.ad_o[23] = c_half[4];
        pins_d.be_n_o[3] = c_half[5];
        pins_d.ad_o[25] = c_half[6];
        pins_d.ad_o[24] = c_half[7];
        pins_d.ad_o[27] = c_half[8];
        pins_d.ad_o[26] = c_half[9];
        pins_d.ad_o[29] = c_half[10];
        pins_d.ad_o[28] = c_half[11];
        pins_d.ad_o[17] = port_c_video.hsync;
        pins_d.ad_o[16] = port_c_video.vsync;
        pins_d.ad_o[18] = c_blank_n;
        pins_d.stb_o = {lk_q, lk_q};
        pins_d.stb_n_o = {!lk_q, !lk_q};
        if (video_q)
        begin
            // Pins 13-15, 30, 31 are inputs in video mode
            pins_d.ad_oe = 32'h3FFF_FFFF & ~32'h0000_E000;
            pins_d.ad_oe[30] = 1'b0;
            pins_d.be_n_oe = 4'hB;
            pins_d.stb_oe = 2'h3;
        end
        if (stall_q)
        begin
            // Syncs and blank keep running so the receiver stays locked
            pins_d.ad_o = pins_d.ad_o & ~32'h3FF8_1FFC;
            pins_d.be_n_o = pins_d.be_n_o & ~4'h9;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            lk_prev_q <= 1'b0;
            pins_o <= '0;
        end
        else
        begin
            lk_prev_q <= lk_q;
            if (lk_edge || !video_q)
                pins_o <= pins_d;
        end
    end

    // ----------------------------------------
    // Display control / DDC open-drain lines
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ddc_oe <= 6'h00;
            ddc_o <= 6'h00;
        end
        else
        begin
            ddc_o <= 6'h00;
            ddc_oe <= video_q ? ddc_drv_q : 6'h00;
        end
    end
endmodule : vpm_top

/* File: shared/vpm_pkg.sv */
package vpm_pkg;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] VPM_ADDR_CTRL = 8'h00;
    localparam logic [7:0] VPM_ADDR_STRAP = 8'h04;
    localparam logic [7:0] VPM_ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] VPM_ADDR_IRQ_CLR = 8'h0C;
    localparam logic [7:0] VPM_ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0] VPM_ADDR_DDC = 8'h14;
    localparam logic [7:0] VPM_ADDR_STATUS = 8'h18;
    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int VPM_CTRL_BORDER = 0;
    localparam int VPM_CTRL_FS_EN = 1;
    localparam int VPM_CTRL_FS_STALL = 2;
    localparam int VPM_CTRL_FS_POL = 3;
    localparam int VPM_CTRL_INTERLEAVE = 4;
    localparam logic [31:0] VPM_CTRL_RST = 32'h0000_0000;
    // Irq status bits
    localparam int VPM_IRQ_DEV = 0;
    localparam int VPM_IRQ_FIELD = 1;
    localparam int VPM_IRQ_STALL = 2;
    localparam int VPM_IRQ_W = 3;
    // Strap register fields
    localparam int VPM_STRAP_VIDEO = 8;
    // Pixel widths
    localparam int VPM_PIX_W = 12;
    localparam int VPM_WORD_W = 24;
    localparam int VPM_NPIN = 32;
    localparam int VPM_NBE = 4;
    // Pin numbers for port B / C data (address-data pins, 99 = byte-enable)
    localparam int VPM_BE_PIN = 99;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic active;
        logic border;
        logic [VPM_WORD_W-1:0] pixel;
    } vpm_video_s;

    typedef struct packed {
        logic [VPM_NPIN-1:0] ad_o;
        logic [VPM_NPIN-1:0] ad_oe;
        logic [VPM_NBE-1:0] be_n_o;
        logic [VPM_NBE-1:0] be_n_oe;
        logic [1:0] stb_o;
        logic [1:0] stb_n_o;
        logic [1:0] stb_oe;
    } vpm_pins_s;
endpackage : vpm_pkg

/* File: tb/vpm_top_properties.sv */
module vpm_top_properties
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic graphics_port_parity_pin,
    input wire logic video_mode_o,
    input wire logic hsync_tick,
    input wire logic stall_hold_o,
    input wire logic [5:0] ddc_o,
    input wire logic [5:0] ddc_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack;
        s_take |=> s_ack_pulse;
    endproperty
    // Checked in reset itself, so no disable
    property p_float;
        disable iff (1'b0) !rst_b ##1 !rst_b |-> ddc_oe == 6'h00;
    endproperty
    property p_open;
        ddc_o == 6'h00;
    endproperty
    property p_mode_cap;
        $rose(rst_b) |=> video_mode_o == !$past(graphics_port_parity_pin);
    endproperty
    property p_mode_hold;
        rst_b && $past(rst_b, 2) |-> $stable(video_mode_o);
    endproperty
    property p_agp_quiet;
        !video_mode_o && !$past(video_mode_o) |-> ddc_oe == 6'h00;
    endproperty
    property p_stall_start;
        $rose(stall_hold_o) |-> $past(hsync_tick);
    endproperty
    property p_stall_line;
        stall_hold_o && !hsync_tick |=> stall_hold_o;
    endproperty
    a_ack: assert property (p_ack) else $error("no single ack after request");
    a_float: assert property (p_float) else $error("display line driven in reset");
    a_open: assert property (p_open) else $error("display line driven high");
    a_mode_cap: assert property (p_mode_cap) else $error("mode differs from strap");
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed after capture");
    a_agp_quiet: assert property (p_agp_quiet) else $error("display line driven in port mode");
    a_stall_start: assert property (p_stall_start) else $error("hold began off a line tick");
    a_stall_line: assert property (p_stall_line) else $error("hold ended inside a line");
endmodule : vpm_top_properties

/* File: tb/vpm_far_end.sv */
module vpm_far_end
(
    input wire logic [5:0] ddc_oe,
    input wire logic [7:0] card_id,
    input wire logic irq_req,
    input wire logic fs_level,
    output logic [5:0] ddc_i,
    output logic [7:0] id_strap,
    output logic irq_n,
    output logic fs_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pull-ups on every line; any enabled driver wins low
    assign ddc_i = ~ddc_oe;
    assign id_strap = card_id;
    assign irq_n = ~irq_req;
    assign fs_out = fs_level;
endmodule : vpm_far_end

/* File: tb/tb.sv */
module tb
    import vpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, par = 1'b0, lclk = 1'b0;
    logic hs = 1'b0, irq_req = 1'b0, fs = 1'b0, ack, irq, vmode, ofield, shold, irq_n, fs_in;
    logic [7:0] adr = 8'h00, card_id = 8'h00, id_strap;
    logic [31:0] dat = 32'h0, rdat, r;
    logic [5:0] ddc_i, ddc_o, ddc_oe;
    vpm_video_s vb = '0, vc = '0;
    vpm_pins_s pins;
    logic [31:0] exp_q[$];
    int error_cnt = 0, samples_checked = 0, seed = 36861, cycles = 0;
    always #2 clk = ~clk;
    // Link clock is free-running and unrelated in phase
    always #62.5 lclk = ~lclk;
    vpm_top vpm_top_inst (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .graphics_port_parity_pin(par), .graphics_sideband_addr_pins(id_strap), .link_clk(lclk),
        .port_b_video(vb), .port_c_video(vc), .pins_o(pins), .video_mode_o(vmode),
        .shared_video_irq_n(irq_n), .port_c_field_stall_in(fs_in), .overlay_field_o(ofield),
        .stall_hold_o(shold), .hsync_tick(hs), .ddc_i(ddc_i), .ddc_o(ddc_o), .ddc_oe(ddc_oe));
    vpm_far_end vpm_far_end_inst (.ddc_oe(ddc_oe), .card_id(card_id), .irq_req(irq_req), .fs_level(fs),
        .ddc_i(ddc_i), .id_strap(id_strap), .irq_n(irq_n), .fs_out(fs_in));
    // ----------------------------------------
    // Compare and bus tasks
    // ----------------------------------------
    task summarize();
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task cmp_rd(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t read %h exp %h", $time, g, e);
        end
    endtask : cmp_rd
    task cmp_lv(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t level %h exp %h", $time, g, e);
        end
    endtask : cmp_lv
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd
    task line();
        hs <= 1'b1;
        @(posedge clk);
        hs <= 1'b0;
    endtask : line
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
            cmp_rd(exp_q.pop_front(), rdat);
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        r = $random(seed);
        card_id <= r[7:0];
        tick(16);
        cmp_lv(32'h0, {26'h0, ddc_oe});
        rst_b <= 1'b1;
        rd(VPM_ADDR_STRAP, {23'h0, 1'b1, card_id});
        wb(1'b1, VPM_ADDR_STRAP, 32'hFF);
        rd(VPM_ADDR_STRAP, {23'h0, 1'b1, card_id});
        rd(8'h40, 32'h0);
        wb(1'b1, VPM_ADDR_IRQ_EN, 32'h1);
        irq_req <= 1'b1;
        tick(8);
        cmp_lv(32'h1, {31'h0, irq});
        irq_req <= 1'b0;
        tick(8);
        rd(VPM_ADDR_IRQ_STAT, 32'h1);
        wb(1'b1, VPM_ADDR_IRQ_CLR, 32'h1);
        tick(3);
        cmp_lv(32'h0, {31'h0, irq});
        wb(1'b1, VPM_ADDR_IRQ_EN, 32'h0);
        irq_req <= 1'b1;
        tick(8);
        cmp_lv(32'h0, {31'h0, irq});
        irq_req <= 1'b0;
        r = $random(seed) & 32'h1F;
        wb(1'b1, VPM_ADDR_CTRL, r);
        rd(VPM_ADDR_CTRL, r);
        wb(1'b1, VPM_ADDR_DDC, 32'h3F);
        tick(4);
        cmp_lv(32'h3F, {26'h0, ddc_oe});
        rd(VPM_ADDR_STATUS, 32'h0);
        wb(1'b1, VPM_ADDR_DDC, 32'h0);
        tick(4);
        rd(VPM_ADDR_STATUS, 32'h3F);
        wb(1'b1, VPM_ADDR_CTRL, 32'h12);
        fs <= 1'b1;
        tick(8);
        cmp_lv(32'h1, {31'h0, ofield});
        fs <= 1'b0;
        tick(8);
        cmp_lv(32'h0, {31'h0, ofield});
        wb(1'b1, VPM_ADDR_CTRL, 32'h1A);
        tick(8);
        cmp_lv(32'h1, {31'h0, ofield});
        wb(1'b1, VPM_ADDR_CTRL, 32'h10);
        fs <= 1'b1;
        tick(8);
        cmp_lv(32'h0, {31'h0, ofield});
        fs <= 1'b0;
        wb(1'b1, VPM_ADDR_CTRL, 32'h06);
        tick(8);
        fs <= 1'b1;
        tick(8);
        line();
        tick(2);
        cmp_lv(32'h1, {31'h0, shold});
        fs <= 1'b0;
        tick(20);
        cmp_lv(32'h1, {31'h0, shold});
        line();
        tick(2);
        cmp_lv(32'h0, {31'h0, shold});
        r = $random(seed);
        wb(1'b1, VPM_ADDR_CTRL, 32'h0);
        vc.border <= 1'b1;
        vb.pixel <= r[23:0];
        tick(100);
        cmp_lv(32'h1, {31'h0, pins.ad_o[18]});
        cmp_lv({31'h0, (pins.stb_o[0] ? r[12] : r[0])}, {31'h0, pins.ad_o[3]});
        cmp_lv(32'h3FFF_1FFF, pins.ad_oe);
        wb(1'b1, VPM_ADDR_CTRL, 32'h1);
        tick(100);
        cmp_lv(32'h0, {31'h0, pins.ad_o[18]});
        vc.active <= 1'b1;
        vc.border <= 1'b0;
        wb(1'b1, VPM_ADDR_CTRL, 32'h0);
        tick(100);
        cmp_lv(32'h0, {31'h0, pins.ad_o[18]});
        rst_b <= 1'b0;
        par <= 1'b1;
        tick(4);
        rst_b <= 1'b1;
        tick(4);
        cmp_lv(32'h0, {31'h0, vmode});
        cmp_lv(32'h0, pins.ad_oe);
        wb(1'b1, VPM_ADDR_DDC, 32'h3F);
        tick(4);
        cmp_lv(32'h0, {26'h0, ddc_oe});
        rd(VPM_ADDR_STRAP, {23'h0, 1'b0, card_id});
        tick(4);
        summarize();
    end
endmodule : tb

bind vpm_top vpm_top_properties vpm_top_properties_inst (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .graphics_port_parity_pin(graphics_port_parity_pin),
    .video_mode_o(video_mode_o), .hsync_tick(hsync_tick), .stall_hold_o(stall_hold_o), .ddc_o(ddc_o),
    .ddc_oe(ddc_oe));
